/* File: common/tmry_pkg.sv */
// Constants shared by the timer Y mode and request flag block
package tmry_pkg;

    // Bus widths
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] MODE_IDX  = 12'h0F7;
    localparam logic [11:0] REQ_IDX   = 12'h0FC;
    localparam logic [11:0] CNT_IDX   = 12'h100;
    localparam logic [11:0] STAT_IDX  = 12'h101;
    localparam logic [11:0] MASK_IDX  = 12'h102;
    localparam logic [11:0] MODE_ADDR = {MODE_IDX[9:0], 2'h0};
    localparam logic [11:0] REQ_ADDR  = {REQ_IDX[9:0], 2'h0};
    localparam logic [11:0] CNT_ADDR  = {CNT_IDX[9:0], 2'h0};
    localparam logic [11:0] STAT_ADDR = {STAT_IDX[9:0], 2'h0};
    localparam logic [11:0] MASK_ADDR = {MASK_IDX[9:0], 2'h0};

    // Values after reset
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] REQ_RST  = 8'h00;
    localparam logic [7:0] CNT_RST  = 8'hFF;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Mode register fields
    localparam int unsigned MODE_LSB  = 0;
    localparam int unsigned MODE_MSB  = 2;
    localparam int unsigned WRCTL_BIT = 3;
    localparam int unsigned LEVEL_BIT = 4;
    localparam int unsigned TRIG_BIT  = 5;
    localparam int unsigned SRC_LSB   = 6;
    localparam int unsigned SRC_MSB   = 7;

    // Operating mode codes
    localparam logic [2:0] MODE_TIMER   = 3'h0;
    localparam logic [2:0] MODE_PULSE   = 3'h1;
    localparam logic [2:0] MODE_PERIOD  = 3'h2;
    localparam logic [2:0] MODE_WIDTH   = 3'h3;
    localparam logic [2:0] MODE_WAVE    = 3'h4;
    localparam logic [2:0] MODE_ONESHOT = 3'h5;
    localparam logic [2:0] MODE_PWM     = 3'h6;
    localparam logic [2:0] MODE_NONE    = 3'h7;

    // Count source codes
    localparam logic [1:0] SRC_DIV2  = 2'h0;
    localparam logic [1:0] SRC_DIV8  = 2'h1;
    localparam logic [1:0] SRC_DIV16 = 2'h2;
    localparam logic [1:0] SRC_PIN   = 2'h3;

    // Prescaler terminal counts (divide ratio minus one)
    localparam logic [3:0] DIV2_LAST  = 4'h1;
    localparam logic [3:0] DIV8_LAST  = 4'h7;
    localparam logic [3:0] DIV16_LAST = 4'hF;

    // Request flag positions
    localparam int unsigned REQ_TX  = 0;
    localparam int unsigned REQ_TY  = 1;
    localparam int unsigned REQ_T1  = 2;
    localparam int unsigned REQ_T2  = 3;
    localparam int unsigned REQ_SRX = 4;
    localparam int unsigned REQ_STX = 5;
    localparam int unsigned REQ_BUS = 6;
    localparam int unsigned REQ_ADC = 7;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Trigger gate for waveform mode
    typedef enum logic {
        TRIG_WAIT,
        TRIG_RUN
    } tmry_trig_t;

endpackage

/* File: design/tmry_sync3.sv */
// Three-stage input synchroniser with agreement filter
module tmry_sync3 (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Asynchronous input and filtered level
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign o_level = level_r;
endmodule

/* File: design/tmry_prescaler.sv */
// Count source prescaler producing one-cycle ticks
module tmry_prescaler
    import tmry_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Divider selection and tick
    input  wire logic [1:0] i_src,
    output logic            o_tick
);
    logic [3:0] div_r;
    logic [3:0] last;

    always_comb begin
        case (i_src)
            SRC_DIV2:  last = DIV2_LAST;
            SRC_DIV8:  last = DIV8_LAST;
            default:   last = DIV16_LAST;
        endcase
    end

    // Restarts early if the ratio shrinks below the running count
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= 4'h0;
        end else if (div_r >= last) begin
            div_r <= 4'h0;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    assign o_tick = (div_r >= last);
endmodule

/* File: design/tmry_top.sv */
// Timer Y mode control, counter and request flag register behind AXI4-Lite
module tmry_top
    import tmry_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    // AXI4-Lite write response
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]      o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // Pins
    input  wire logic              i_timer_y_counter_pin,
    output logic                   o_timer_y_counter_pin_out,
    output logic                   o_timer_y_counter_pin_oe,
    input  wire logic              i_external_trigger_pin,
    // Request sources and interrupt
    input  wire logic [7:0]        i_req_events,
    output logic                   o_irq
);
    import tmry_pkg::*;

    // Registers
    logic [7:0]        mode_r;
    logic [7:0]        req_r;
    logic [7:0]        latch_r;
    logic [7:0]        cnt_r;
    logic [7:0]        stat_r;
    logic [7:0]        mask_r;
    logic              irq_r;
    logic              pin_out_r;
    logic              pin_oe_r;
    tmry_trig_t        trig_r;
    logic              pin_lvl_d_r;
    logic              trig_lvl_d_r;

    // Bus state
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              aw_have_r;
    logic              w_have_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0]        w_byte_r;
    logic              w_lane_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rdata_r;

    // Decoded fields and strobes
    logic [2:0]        op_mode;
    logic              wr_latch_only;
    logic              lvl_bit;
    logic              trig_sel;
    logic [1:0]        cnt_src;
    logic              do_wr;
    logic              wr_en;
    logic              wr_mode;
    logic              wr_req;
    logic              wr_cnt;
    logic              wr_mask;
    logic              ar_hs;
    logic              rd_stat;
    logic              pin_lvl;
    logic              trig_lvl;
    logic              pin_rise;
    logic              trig_rise;
    logic              pre_tick;
    logic              tick;
    logic              running;
    logic              underflow;
    logic              out_mode;
    logic [7:0]        req_set;
    logic [7:0]        req_keep;
    logic [7:0]        stat_keep;
    logic [7:0]        mode_nxt;

    assign op_mode       = mode_r[MODE_MSB:MODE_LSB];
    assign wr_latch_only = mode_r[WRCTL_BIT];
    assign lvl_bit       = mode_r[LEVEL_BIT];
    assign trig_sel      = mode_r[TRIG_BIT];
    assign cnt_src       = mode_r[SRC_MSB:SRC_LSB];

    // Pin inputs cross from outside the clock domain
    tmry_sync3 u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_timer_y_counter_pin),
        .o_level (pin_lvl)
    );

    tmry_sync3 u_trig_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_external_trigger_pin),
        .o_level (trig_lvl)
    );

    tmry_prescaler u_presc (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_src   (cnt_src),
        .o_tick  (pre_tick)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_lvl_d_r  <= 1'b0;
            trig_lvl_d_r <= 1'b0;
        end else begin
            pin_lvl_d_r  <= pin_lvl;
            trig_lvl_d_r <= trig_lvl;
        end
    end

    assign pin_rise  = pin_lvl & ~pin_lvl_d_r;
    assign trig_rise = trig_lvl & ~trig_lvl_d_r;

    // Count tick from the prescaler or the counter pin
    assign tick = (cnt_src == SRC_PIN) ? pin_rise : pre_tick;

    // Write channel: address and data may arrive in either order
    assign do_wr   = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_en   = do_wr & w_lane_r;
    assign wr_mode = wr_en & (aw_addr_r == MODE_ADDR);
    assign wr_req  = wr_en & (aw_addr_r == REQ_ADDR);
    assign wr_cnt  = wr_en & (aw_addr_r == CNT_ADDR);
    assign wr_mask = wr_en & (aw_addr_r == MASK_ADDR);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            awready_r <= 1'b1;
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (i_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_have_r <= 1'b1;
            aw_addr_r <= {i_awaddr[ADDR_W-1:2], 2'h0};
        end else if (do_wr) begin
            aw_have_r <= 1'b0;
        end else if (bvalid_r && i_bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wready_r <= 1'b1;
            w_have_r <= 1'b0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
        end else if (i_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_have_r <= 1'b1;
            w_byte_r <= i_wdata[7:0];
            w_lane_r <= i_wstrb[0];
        end else if (do_wr) begin
            w_have_r <= 1'b0;
        end else if (bvalid_r && i_bready) begin
            wready_r <= 1'b1;
        end
    end

    // Unmapped addresses answer with a slave error and change nothing
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            case (aw_addr_r)
                MODE_ADDR, REQ_ADDR, CNT_ADDR, STAT_ADDR, MASK_ADDR: bresp_r <= RESP_OKAY;
                default: bresp_r <= RESP_SLVERR;
            endcase
        end else if (bvalid_r && i_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Mode register; the reserved code is refused and the old mode kept
    always_comb begin
        mode_nxt = w_byte_r;
        if (w_byte_r[MODE_MSB:MODE_LSB] == MODE_NONE) begin
            mode_nxt[MODE_MSB:MODE_LSB] = op_mode;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r <= MODE_RST;
        end else if (wr_mode) begin
            mode_r <= mode_nxt;
        end
    end

    // Waveform mode start gate
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trig_r <= TRIG_WAIT;
        end else begin
            case (trig_r)
                TRIG_WAIT: begin
                    if (op_mode == MODE_WAVE && trig_sel && trig_rise) begin
                        trig_r <= TRIG_RUN;
                    end
                end
                TRIG_RUN: begin
                    if (op_mode != MODE_WAVE || !trig_sel) begin
                        trig_r <= TRIG_WAIT;
                    end
                end
                default: trig_r <= TRIG_WAIT;
            endcase
        end
    end

    // Only waveform mode with trigger selected waits for the trigger pin
    assign running   = !(op_mode == MODE_WAVE && trig_sel) || (trig_r == TRIG_RUN);
    assign underflow = tick & running & (cnt_r == 8'h00);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_r <= CNT_RST;
        end else if (wr_cnt) begin
            latch_r <= w_byte_r;
        end
    end

    // A direct write outranks a tick in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= CNT_RST;
        end else if (wr_cnt && !wr_latch_only) begin
            cnt_r <= w_byte_r;
        end else if (underflow) begin
            cnt_r <= latch_r;
        end else if (tick && running) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    // Counter pin drive; pulse output mode toggles on each underflow
    assign out_mode = (op_mode == MODE_PULSE) || (op_mode == MODE_WAVE) ||
                      (op_mode == MODE_ONESHOT) || (op_mode == MODE_PWM);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_out_r <= 1'b0;
            pin_oe_r  <= 1'b0;
        end else begin
            if (wr_mode) begin
                pin_out_r <= w_byte_r[LEVEL_BIT];
            end else if (op_mode == MODE_PULSE && underflow) begin
                pin_out_r <= ~pin_out_r;
            end else if (op_mode != MODE_PULSE) begin
                pin_out_r <= lvl_bit;
            end
            // The pin cannot drive while it is the count source
            pin_oe_r <= out_mode && (cnt_src != SRC_PIN);
        end
    end

    // Request flags: set wins over a write of zero
    always_comb begin
        req_set         = i_req_events;
        req_set[REQ_TY] = i_req_events[REQ_TY] | underflow;
        req_keep        = wr_req ? w_byte_r : 8'hFF;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_r <= REQ_RST;
        end else begin
            req_r <= (req_r & req_keep) | req_set;
        end
    end

    // Sticky interrupt status, cleared by a read; set wins
    assign ar_hs     = i_arvalid & arready_r;
    assign rd_stat   = ar_hs & ({i_araddr[ADDR_W-1:2], 2'h0} == STAT_ADDR);
    assign stat_keep = rd_stat ? 8'h00 : 8'hFF;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_r <= STAT_RST;
        end else begin
            stat_r <= (stat_r & stat_keep) | req_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_r <= MASK_RST;
        end else if (wr_mask) begin
            mask_r <= w_byte_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // Read channel: one outstanding read, data registered
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end else if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
            case ({i_araddr[ADDR_W-1:2], 2'h0})
                MODE_ADDR: rdata_r[7:0] <= mode_r;
                REQ_ADDR:  rdata_r[7:0] <= req_r;
                CNT_ADDR:  rdata_r[7:0] <= cnt_r;
                STAT_ADDR: rdata_r[7:0] <= stat_r;
                MASK_ADDR: rdata_r[7:0] <= mask_r;
                default:   rresp_r      <= RESP_SLVERR;
            endcase
        end else if (rvalid_r && i_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign o_awready                 = awready_r;
    assign o_wready                  = wready_r;
    assign o_bresp                   = bresp_r;
    assign o_bvalid                  = bvalid_r;
    assign o_arready                 = arready_r;
    assign o_rdata                   = rdata_r;
    assign o_rresp                   = rresp_r;
    assign o_rvalid                  = rvalid_r;
    assign o_timer_y_counter_pin_out = pin_out_r;
    assign o_timer_y_counter_pin_oe  = pin_oe_r;
    assign o_irq                     = irq_r;
endmodule

/* File: verification/tmry_top_asserts.sv */
// Bus handshake and interrupt timing checks for the timer Y block
module tmry_top_asserts (
    // Clock and reset
    input wire logic                        i_clk,
    input wire logic                        i_rst_n,
    // Write channels
    input wire logic                        i_awvalid,
    input wire logic                        o_awready,
    input wire logic                        i_wvalid,
    input wire logic                        o_wready,
    input wire logic                        o_bvalid,
    input wire logic                        i_bready,
    // Read channels
    input wire logic                        i_arvalid,
    input wire logic                        o_arready,
    input wire logic [tmry_pkg::DATA_W-1:0] o_rdata,
    input wire logic                        o_rvalid,
    input wire logic                        i_rready,
    // Interrupt
    input wire logic                        o_irq
);
    import tmry_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_rd_taken;
        i_arvalid && o_arready;
    endsequence
    sequence s_rd_done;
        o_rvalid && i_rready;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |=> !o_bvalid ##1 o_bvalid)
        else $error("write response not two cycles after address");
    AST_WR_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write ready while response pending");
    AST_B_RELEASE: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready)
        else $error("write channel not reopened");
    AST_RD_ANSWER: assert property (s_rd_taken |=> o_rvalid)
        else $error("read data not one cycle after address");
    AST_RD_BLOCK: assert property (o_rvalid |-> !o_arready)
        else $error("read ready while data pending");
    AST_R_RELEASE: assert property (s_rd_done |=> !o_rvalid && o_arready)
        else $error("read channel not reopened");
    AST_RDATA_BYTE: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    // Only a read clear or a mask write may drop the interrupt
    AST_IRQ_STICKY: assert property (o_irq && !o_rvalid && !o_bvalid && !(i_arvalid && o_arready) |=> o_irq)
        else $error("interrupt dropped without clear");
endmodule

bind tmry_top tmry_top_asserts tmry_top_asserts_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_irq(o_irq)
);

/* File: verification/tmry_pin_model.sv */
// Far side model driving the counter pin and the external trigger pin
module tmry_pin_model (
    // Clock
    input  wire logic i_clk,
    // Pins toward the block
    output logic      o_counter_pin,
    output logic      o_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_counter_pin = 1'b0;
        o_trigger_pin = 1'b0;
    end
    // Each level held long enough for the synchroniser filter
    task automatic pulse_pin(input int n, input int hold);
        repeat (n) begin
            @(posedge i_clk);
            o_counter_pin <= 1'b1;
            repeat (hold) @(posedge i_clk);
            o_counter_pin <= 1'b0;
            repeat (hold) @(posedge i_clk);
        end
    endtask
    task automatic pulse_trig();
        @(posedge i_clk);
        o_trigger_pin <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_trigger_pin <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the timer Y mode and request flag block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tmry_pkg::*;
    typedef struct {string name; logic [33:0] exp; logic [33:0] care;} tmry_note_t;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic              clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, cpin, trig, pin_out, pin_oe, irq;
    logic [7:0]        events, v, d;
    int                fails, check_count, cycles, t, div;
    int                seed = 74;
    tmry_note_t        notes[$];

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    tmry_top tmry_top_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_timer_y_counter_pin(cpin), .o_timer_y_counter_pin_out(pin_out),
        .o_timer_y_counter_pin_oe(pin_oe), .i_external_trigger_pin(trig), .i_req_events(events),
        .o_irq(irq)
    );
    tmry_pin_model tmry_pin_model_inst (.i_clk(clk), .o_counter_pin(cpin), .o_trigger_pin(trig));

    task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] dv, input logic [1:0] resp = RESP_OKAY);
        @(posedge clk);
        notes.push_back('{"write response", {resp, 32'h0}, {2'h3, 32'h0}});
        awaddr <= a;
        wdata <= {24'h0, dv};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] dv, input string name,
                      input logic [7:0] care = 8'hFF, input logic [1:0] resp = RESP_OKAY);
        @(posedge clk);
        notes.push_back('{name, {resp, 24'h0, dv}, {2'h3, 24'hFFFFFF, care}});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask

    task automatic fire(input logic [7:0] e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= 8'h00;
        repeat (2) @(posedge clk);
    endtask

    // Oldest note matches the next bus answer
    always @(posedge clk) begin
        tmry_note_t n;
        if ((rvalid && rready) || (bvalid && bready)) begin
            n = notes.pop_front();
            chk(n.name, n.exp & n.care, (rvalid ? {rresp, rdata} : {bresp, 32'h0}) & n.care);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, events} = '0;
        wstrb = 4'hF;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Counter counts from reset; read it before its first tick lands
        rd(CNT_ADDR, CNT_RST, "counter reset");
        rd(MODE_ADDR, MODE_RST, "mode reset");
        rd(REQ_ADDR, REQ_RST, "request reset");
        for (int c = 0; c < 8; c++) begin
            v = 8'($random(seed));
            v[2:0] = c[2:0];
            wr(MODE_ADDR, v);
            if (c == 7) v[2:0] = 3'h6;
            rd(MODE_ADDR, v, "mode field");
        end
        wr(12'h010, 8'h5A, RESP_SLVERR);
        rd(12'h010, 8'h00, "unmapped read", 8'hFF, RESP_SLVERR);
        wr(MODE_ADDR, 8'hC0);
        rd(STAT_ADDR, 8'h00, "status clear", 8'h00);
        wr(REQ_ADDR, 8'h00);
        rd(REQ_ADDR, 8'h00, "request cleared");
        v = 8'($random(seed));
        fire(v);
        rd(REQ_ADDR, v, "request set");
        fire(8'hFF);
        for (int n = 0; n < 8; n++) begin
            wr(REQ_ADDR, ~(8'h01 << n));
            rd(REQ_ADDR, 8'hFE << n, "request clear one");
        end
        rd(STAT_ADDR, 8'h00, "status clear", 8'h00);
        wr(MASK_ADDR, 8'h20);
        fire(8'h10);
        chk("irq masked", 1'b0, irq);
        fire(8'h20);
        chk("irq raised", 1'b1, irq);
        rd(STAT_ADDR, 8'h30, "status sticky");
        repeat (3) @(posedge clk);
        chk("irq cleared", 1'b0, irq);
        wr(MODE_ADDR, 8'h14);
        repeat (2) @(posedge clk);
        chk("pin high", 2'b11, {pin_out, pin_oe});
        wr(MODE_ADDR, 8'h04);
        repeat (2) @(posedge clk);
        chk("pin low", 2'b01, {pin_out, pin_oe});
        // Byte lane off: the write is answered but changes nothing
        wstrb <= 4'hE;
        wr(MODE_ADDR, 8'hC0);
        wstrb <= 4'hF;
        rd(MODE_ADDR, 8'h04, "strobe off write");
        wr(MODE_ADDR, 8'hC0);
        d = {1'b1, 7'($random(seed))};
        wr(CNT_ADDR, d);
        rd(CNT_ADDR, d, "counter write");
        wr(MODE_ADDR, 8'hC8);
        wr(CNT_ADDR, ~d);
        rd(CNT_ADDR, d, "latch only write");
        tmry_pin_model_inst.pulse_pin(3, 6);
        rd(CNT_ADDR, d - 8'h03, "pin counted");
        wr(MODE_ADDR, 8'hE4);
        wr(CNT_ADDR, 8'h20);
        tmry_pin_model_inst.pulse_pin(2, 12);
        rd(CNT_ADDR, 8'h20, "waiting trigger");
        tmry_pin_model_inst.pulse_trig();
        tmry_pin_model_inst.pulse_pin(2, 12);
        rd(CNT_ADDR, 8'h1E, "triggered run");
        for (int c = 0; c < 3; c++) begin
            div = (c == 0) ? 2 : (c == 1) ? 8 : 16;
            wr(MODE_ADDR, 8'hC0);
            wr(CNT_ADDR, 8'h03);
            rd(STAT_ADDR, 8'h00, "status clear", 8'h00);
            wr(MASK_ADDR, 8'h02);
            wr(MODE_ADDR, {c[1:0], 6'h00});
            t = 0;
            while (irq !== 1'b1 && t < 200) begin
                @(posedge clk);
                t++;
            end
            chk("divide low", 1'b1, t >= 3 * div);
            chk("divide high", 1'b1, t <= 4 * div + 8);
        end
        // Pulse output mode toggles the pin level on underflow
        wr(MODE_ADDR, 8'hC1);
        wr(CNT_ADDR, 8'h01);
        tmry_pin_model_inst.pulse_pin(2, 6);
        chk("pulse toggle", 2'b10, {pin_out, pin_oe});
        rd(CNT_ADDR, 8'h01, "pulse reload");
        conclude();
    end
endmodule
